//--- hdl/bgp_pkg.sv
`default_nettype none
package bgp_pkg;
  // ==========================================================
  // port widths and synchroniser depth
  localparam int unsigned P1_W   = 8;
  localparam int unsigned P2_W   = 5;
  localparam int unsigned P3_W   = 8;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned SYNC_N = 2;
  // ==========================================================
  // register indices, byte address is four times the index
  localparam logic [5:0] IDX_ONE_DATA  = 6'h01;
  localparam logic [5:0] IDX_TWO_DATA  = 6'h02;
  localparam logic [5:0] IDX_THR_DATA  = 6'h03;
  localparam logic [5:0] IDX_ONE_DIR   = 6'h05;
  localparam logic [5:0] IDX_TWO_DIR   = 6'h06;
  localparam logic [5:0] IDX_THR_DIR   = 6'h07;
  localparam logic [5:0] IDX_OPTION    = 6'h1d;
  localparam logic [5:0] IDX_KEY_EN    = 6'h20;
  // ==========================================================
  // shared option register fields
  localparam int unsigned OPT_ONE_PU_BIT = 1;
  localparam int unsigned OPT_TWO_PU_BIT = 2;
  localparam int unsigned OPT_DRIVE_BIT  = 5;
  localparam logic        OPT_PU_RST     = 1'b0;
  localparam logic        OPT_DRIVE_RST  = 1'b1;
  // ==========================================================
  // other reset values
  localparam logic [7:0]  DIR_RST        = 8'h00;
  localparam logic [7:0]  KEY_EN_RST     = 8'h00;
endpackage : bgp_pkg
`default_nettype wire

//--- hdl/bgp_ports.sv
`default_nettype none
module bgp_ports #(
  parameter int unsigned P1_W = bgp_pkg::P1_W,
  parameter int unsigned P2_W = bgp_pkg::P2_W,
  parameter int unsigned P3_W = bgp_pkg::P3_W
) (
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [bgp_pkg::ADDR_W-1:0]  paddr,
  input  wire logic [bgp_pkg::DATA_W-1:0]  pwdata,
  output logic      [bgp_pkg::DATA_W-1:0]  prdata,
  output logic                             pready,
  output logic                             pslverr,
  input  wire logic [P1_W-1:0]             port_one_in,
  output logic      [P1_W-1:0]             port_one_out,
  output logic      [P1_W-1:0]             port_one_oe_n,
  output logic      [P1_W-1:0]             port_one_pu,
  input  wire logic [P2_W-1:0]             port_two_in,
  output logic      [P2_W-1:0]             port_two_out,
  output logic      [P2_W-1:0]             port_two_oe_n,
  output logic      [P2_W-1:0]             port_two_pu,
  output logic                             direct_drive_select,
  input  wire logic [P3_W-1:0]             port_three_in,
  output logic      [P3_W-1:0]             port_three_out,
  output logic      [P3_W-1:0]             port_three_oe_n,
  output logic      [P3_W-1:0]             port_three_pu,
  output logic      [P3_W-1:0]             port_three_keypad_irq_enables,
  output logic      [P3_W-1:0]             port_three_keypad_level
);

  // ==========================================================
  // parameter check
  if (P1_W < 1 || P1_W > 8 || P2_W < 1 || P2_W > 8 ||
      P3_W < 1 || P3_W > 8) begin : g_chk
    $error("port widths must lie between 1 and 8");
  end

  // ==========================================================
  // state
  logic [P1_W-1:0] one_lat_r;
  logic [P2_W-1:0] two_lat_r;
  logic [P3_W-1:0] thr_lat_r;
  logic [P1_W-1:0] one_dir_r;
  logic [P2_W-1:0] two_dir_r;
  logic [P3_W-1:0] thr_dir_r;
  logic            opt_one_pu_r;
  logic            opt_two_pu_r;
  logic            opt_drive_r;
  logic [P3_W-1:0] key_en_r;
  logic [P1_W-1:0] one_s1_r;
  logic [P1_W-1:0] one_s2_r;
  logic [P2_W-1:0] two_s1_r;
  logic [P2_W-1:0] two_s2_r;
  logic [P3_W-1:0] thr_s1_r;
  logic [P3_W-1:0] thr_s2_r;
  logic [31:0]     prdata_r;
  logic            pready_r;
  logic            pslverr_r;
  logic [P1_W-1:0] one_out_r;
  logic [P1_W-1:0] one_oe_n_r;
  logic [P1_W-1:0] one_pu_r;
  logic [P2_W-1:0] two_out_r;
  logic [P2_W-1:0] two_oe_n_r;
  logic [P2_W-1:0] two_pu_r;
  logic            drive_r;
  logic [P3_W-1:0] thr_out_r;
  logic [P3_W-1:0] thr_oe_n_r;
  logic [P3_W-1:0] thr_pu_r;
  logic [P3_W-1:0] key_out_r;

  // ==========================================================
  // bus decode
  wire        setup  = psel & ~penable;
  wire        wr_acc = psel & penable & pwrite & pready_r;
  wire [5:0]  idx    = paddr[7:2];
  wire        algn   = (paddr[1:0] == 2'h0);
  wire        h_1d   = algn & (idx == bgp_pkg::IDX_ONE_DATA);
  wire        h_2d   = algn & (idx == bgp_pkg::IDX_TWO_DATA);
  wire        h_3d   = algn & (idx == bgp_pkg::IDX_THR_DATA);
  wire        h_1r   = algn & (idx == bgp_pkg::IDX_ONE_DIR);
  wire        h_2r   = algn & (idx == bgp_pkg::IDX_TWO_DIR);
  wire        h_3r   = algn & (idx == bgp_pkg::IDX_THR_DIR);
  wire        h_opt  = algn & (idx == bgp_pkg::IDX_OPTION);
  wire        h_key  = algn & (idx == bgp_pkg::IDX_KEY_EN);
  wire        hit    = h_1d | h_2d | h_3d | h_1r | h_2r | h_3r |
                       h_opt | h_key;

  // ==========================================================
  // readback: latch on outputs, synchronised pin on inputs
  wire [P1_W-1:0] one_rd = (one_dir_r & one_lat_r) |
                           (~one_dir_r & one_s2_r);
  wire [P2_W-1:0] two_rd = (two_dir_r & two_lat_r) |
                           (~two_dir_r & two_s2_r);
  wire [P3_W-1:0] thr_rd = (thr_dir_r & thr_lat_r) |
                           (~thr_dir_r & thr_s2_r);

  wire [7:0] opt_rd;
  assign opt_rd = (8'(opt_drive_r)  << bgp_pkg::OPT_DRIVE_BIT) |
                  (8'(opt_two_pu_r) << bgp_pkg::OPT_TWO_PU_BIT) |
                  (8'(opt_one_pu_r) << bgp_pkg::OPT_ONE_PU_BIT);

  wire [31:0] rd_mux;
  assign rd_mux = h_1d  ? 32'(one_rd)    :
                  h_2d  ? 32'(two_rd)    :
                  h_3d  ? 32'(thr_rd)    :
                  h_1r  ? 32'(one_dir_r) :
                  h_2r  ? 32'(two_dir_r) :
                  h_3r  ? 32'(thr_dir_r) :
                  h_opt ? 32'(opt_rd)    :
                  h_key ? 32'(key_en_r)  :
                          32'h0000_0000;

  // ==========================================================
  // bus answer, ready in the first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h0000_0000;
    end else begin
      pready_r  <= setup;
      pslverr_r <= setup & ~hit;
      if (setup && !pwrite) begin
        prdata_r <= rd_mux;
      end
    end
  end

  // ==========================================================
  // data latches, no reset on purpose
  always_ff @(posedge pclk) begin
    if (wr_acc && h_1d) begin
      one_lat_r <= pwdata[P1_W-1:0];
    end
    if (wr_acc && h_2d) begin
      two_lat_r <= pwdata[P2_W-1:0];
    end
    if (wr_acc && h_3d) begin
      thr_lat_r <= pwdata[P3_W-1:0];
    end
  end

  // ==========================================================
  // direction, option and keypad enable registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      one_dir_r    <= P1_W'(bgp_pkg::DIR_RST);
      two_dir_r    <= P2_W'(bgp_pkg::DIR_RST);
      thr_dir_r    <= P3_W'(bgp_pkg::DIR_RST);
      opt_one_pu_r <= bgp_pkg::OPT_PU_RST;
      opt_two_pu_r <= bgp_pkg::OPT_PU_RST;
      opt_drive_r  <= bgp_pkg::OPT_DRIVE_RST;
      key_en_r     <= P3_W'(bgp_pkg::KEY_EN_RST);
    end else begin
      if (wr_acc && h_1r) begin
        one_dir_r <= pwdata[P1_W-1:0];
      end
      if (wr_acc && h_2r) begin
        two_dir_r <= pwdata[P2_W-1:0];
      end
      if (wr_acc && h_3r) begin
        thr_dir_r <= pwdata[P3_W-1:0];
      end
      if (wr_acc && h_opt) begin
        opt_one_pu_r <= pwdata[bgp_pkg::OPT_ONE_PU_BIT];
        opt_two_pu_r <= pwdata[bgp_pkg::OPT_TWO_PU_BIT];
        opt_drive_r  <= pwdata[bgp_pkg::OPT_DRIVE_BIT];
      end
      if (wr_acc && h_key) begin
        key_en_r <= pwdata[P3_W-1:0];
      end
    end
  end

  // ==========================================================
  // pin synchronisers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      one_s1_r <= '0;
      one_s2_r <= '0;
      two_s1_r <= '0;
      two_s2_r <= '0;
      thr_s1_r <= '0;
      thr_s2_r <= '0;
    end else begin
      one_s1_r <= port_one_in;
      one_s2_r <= one_s1_r;
      two_s1_r <= port_two_in;
      two_s2_r <= two_s1_r;
      thr_s1_r <= port_three_in;
      thr_s2_r <= thr_s1_r;
    end
  end

  // ==========================================================
  // pin drivers, enable and value move on the same edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      one_out_r  <= '0;
      one_oe_n_r <= '1;
      one_pu_r   <= '0;
      two_out_r  <= '0;
      two_oe_n_r <= '1;
      two_pu_r   <= '0;
      drive_r    <= bgp_pkg::OPT_DRIVE_RST;
      thr_out_r  <= '0;
      thr_oe_n_r <= '1;
      thr_pu_r   <= '0;
      key_out_r  <= '0;
    end else begin
      one_out_r  <= one_lat_r & one_dir_r;
      one_oe_n_r <= ~one_dir_r;
      one_pu_r   <= {P1_W{opt_one_pu_r}} & ~one_dir_r;
      two_out_r  <= two_lat_r & two_dir_r;
      two_oe_n_r <= ~two_dir_r;
      two_pu_r   <= {P2_W{opt_two_pu_r}} & ~two_dir_r;
      drive_r    <= opt_drive_r;
      thr_out_r  <= thr_lat_r & thr_dir_r;
      thr_oe_n_r <= ~thr_dir_r;
      thr_pu_r   <= key_en_r & ~thr_dir_r;
      key_out_r  <= key_en_r;
    end
  end

  // ==========================================================
  // outputs
  assign prdata                        = prdata_r;
  assign pready                        = pready_r;
  assign pslverr                       = pslverr_r;
  assign port_one_out                  = one_out_r;
  assign port_one_oe_n                 = one_oe_n_r;
  assign port_one_pu                   = one_pu_r;
  assign port_two_out                  = two_out_r;
  assign port_two_oe_n                 = two_oe_n_r;
  assign port_two_pu                   = two_pu_r;
  assign direct_drive_select           = drive_r;
  assign port_three_out                = thr_out_r;
  assign port_three_oe_n               = thr_oe_n_r;
  assign port_three_pu                 = thr_pu_r;
  assign port_three_keypad_irq_enables = key_out_r;
  assign port_three_keypad_level       = thr_s2_r;

  // ==========================================================
  // assertions
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_ready;
    setup |=> pready ##1 !pready;
  endproperty
  a_ready: assert property (p_ready)
    else $error("pready not one cycle after setup");

  property p_rd_one;
    (setup && !pwrite && h_1d) |=>
      prdata[P1_W-1:0] == $past(one_rd);
  endproperty
  a_rd_one: assert property (p_rd_one)
    else $error("first port read data wrong");

  property p_rd_pin;
    (setup && !pwrite && h_3d && thr_dir_r == '0) |=>
      prdata[P3_W-1:0] == $past(thr_s2_r);
  endproperty
  a_rd_pin: assert property (p_rd_pin)
    else $error("input read did not return pin level");

  property p_wr_lat;
    (wr_acc && h_1d) |=> one_lat_r == $past(pwdata[P1_W-1:0]);
  endproperty
  a_wr_lat: assert property (p_wr_lat)
    else $error("latch not loaded by write");

  property p_drive_pin;
    (wr_acc && h_2r) |=> ##1
      port_two_oe_n == ~$past(pwdata[P2_W-1:0], 2);
  endproperty
  a_drive_pin: assert property (p_drive_pin)
    else $error("output enable does not follow direction");

  property p_two_hi;
    (setup && !pwrite && h_2r) |=> prdata[31:P2_W] == '0;
  endproperty
  a_two_hi: assert property (p_two_hi)
    else $error("unused direction bits not zero");

  property p_pu_one;
    ##1 port_one_pu == ($past({P1_W{opt_one_pu_r}}) &
                        ~$past(one_dir_r));
  endproperty
  a_pu_one: assert property (p_pu_one)
    else $error("first port pull-up wrong");

  property p_pu_thr;
    ##1 port_three_pu == ($past(key_en_r) & ~$past(thr_dir_r));
  endproperty
  a_pu_thr: assert property (p_pu_thr)
    else $error("keypad pull-up wrong");

  property p_drv_opt;
    (wr_acc && h_opt) |=> ##1
      direct_drive_select == $past(pwdata[bgp_pkg::OPT_DRIVE_BIT], 2);
  endproperty
  a_drv_opt: assert property (p_drv_opt)
    else $error("direct drive select not updated");

  property p_dir_rst;
    $rose(presetn) |-> one_dir_r == '0 && port_two_oe_n == '1;
  endproperty
  a_dir_rst: assert property (p_dir_rst)
    else $error("direction not cleared by reset");

  c_wr_one:  cover property (wr_acc && h_1d);
  c_rd_mix:  cover property (setup && !pwrite && h_1d &&
                             one_dir_r != '0 && ~one_dir_r != '0);
  c_key_en:  cover property (wr_acc && h_key && pwdata[0]);
  c_err:     cover property (pslverr && pready);

endmodule : bgp_ports
`default_nettype wire

//--- verif/tb_bidir_gpio_ports_bcd.sv
`default_nettype none
module tb_bidir_gpio_ports_bcd;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // signals
  logic        pclk, presetn, psel, penable, pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        pready, pslverr, err;
  logic [7:0]  p1_in, p1_out, p1_oe_n, p1_pu;
  logic [4:0]  p2_in, p2_out, p2_oe_n, p2_pu;
  logic [7:0]  p3_in, p3_out, p3_oe_n, p3_pu, kp_en, kp_lvl;
  logic        drv;
  int          error_cnt, num_checks;

  bgp_ports u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr),
    .port_one_in(p1_in), .port_one_out(p1_out),
    .port_one_oe_n(p1_oe_n), .port_one_pu(p1_pu),
    .port_two_in(p2_in), .port_two_out(p2_out),
    .port_two_oe_n(p2_oe_n), .port_two_pu(p2_pu),
    .direct_drive_select(drv),
    .port_three_in(p3_in), .port_three_out(p3_out),
    .port_three_oe_n(p3_oe_n), .port_three_pu(p3_pu),
    .port_three_keypad_irq_enables(kp_en),
    .port_three_keypad_level(kp_lvl)
  );

  // ==========================================================
  // clock and watchdog
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  initial begin
    #100us;
    error_cnt++;
    end_of_test();
  end

  // ==========================================================
  // shared tasks
  task automatic chk(string name, logic [31:0] seen, logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic apb(logic wr, logic [5:0] idx, logic [31:0] wd);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= {idx, 2'b00};
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rchk(string name, logic [5:0] idx, logic [31:0] exp);
    apb(1'b0, idx, 32'h0);
    chk(name, rd, exp);
  endtask : rchk

  task automatic settle();
    repeat (3) @(posedge pclk);
    #1;
  endtask : settle

  task automatic do_reset();
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
  endtask : do_reset

  // ==========================================================
  // scenarios
  task automatic t_reset_vals();
    rchk("dir1", bgp_pkg::IDX_ONE_DIR, 32'h0);
    rchk("dir2", bgp_pkg::IDX_TWO_DIR, 32'h0);
    rchk("dir3", bgp_pkg::IDX_THR_DIR, 32'h0);
    rchk("opt", bgp_pkg::IDX_OPTION, 32'h20);
    rchk("kpen", bgp_pkg::IDX_KEY_EN, 32'h0);
    chk("oe1", {24'h0, p1_oe_n}, 32'hff);
    chk("oe3", {24'h0, p3_oe_n}, 32'hff);
    chk("drv", {31'h0, drv}, 32'h1);
  endtask : t_reset_vals

  task automatic t_port_one();
    apb(1'b1, bgp_pkg::IDX_ONE_DATA, 32'ha5);
    apb(1'b1, bgp_pkg::IDX_ONE_DIR, 32'h0f);
    p1_in <= 8'h3c;
    settle();
    rchk("rd1", bgp_pkg::IDX_ONE_DATA, 32'h35);
    chk("out1", {24'h0, p1_out}, 32'h05);
    chk("oe1", {24'h0, p1_oe_n}, 32'hf0);
    apb(1'b1, bgp_pkg::IDX_ONE_DATA, 32'h5a);
    rchk("rd1b", bgp_pkg::IDX_ONE_DATA, 32'h3a);
    apb(1'b1, bgp_pkg::IDX_ONE_DIR, 32'hff);
    rchk("rd1c", bgp_pkg::IDX_ONE_DATA, 32'h5a);
  endtask : t_port_one

  task automatic t_port_two();
    apb(1'b1, bgp_pkg::IDX_TWO_DATA, 32'h15);
    apb(1'b1, bgp_pkg::IDX_TWO_DIR, 32'hff);
    rchk("dir2", bgp_pkg::IDX_TWO_DIR, 32'h1f);
    apb(1'b1, bgp_pkg::IDX_TWO_DIR, 32'h03);
    p2_in <= 5'h0a;
    settle();
    rchk("rd2", bgp_pkg::IDX_TWO_DATA, 32'h09);
    chk("out2", {27'h0, p2_out}, 32'h01);
    chk("oe2", {27'h0, p2_oe_n}, 32'h1c);
  endtask : t_port_two

  task automatic t_port_three();
    apb(1'b1, bgp_pkg::IDX_THR_DATA, 32'h81);
    rchk("rd3p", bgp_pkg::IDX_THR_DATA, 32'h0);
    apb(1'b1, bgp_pkg::IDX_THR_DIR, 32'h03);
    apb(1'b1, bgp_pkg::IDX_KEY_EN, 32'h0f);
    p3_in <= 8'h5a;
    settle();
    rchk("rd3", bgp_pkg::IDX_THR_DATA, 32'h59);
    chk("kpen", {24'h0, kp_en}, 32'h0f);
    chk("pu3", {24'h0, p3_pu}, 32'h0c);
    chk("kplv", {24'h0, kp_lvl}, 32'h5a);
    chk("out3", {24'h0, p3_out}, 32'h01);
    chk("oe3", {24'h0, p3_oe_n}, 32'hfc);
  endtask : t_port_three

  task automatic t_option();
    apb(1'b1, bgp_pkg::IDX_OPTION, 32'hff);
    rchk("opt", bgp_pkg::IDX_OPTION, 32'h26);
    apb(1'b1, bgp_pkg::IDX_ONE_DIR, 32'h0f);
    apb(1'b1, bgp_pkg::IDX_OPTION, 32'h06);
    settle();
    chk("pu1", {24'h0, p1_pu}, 32'hf0);
    chk("pu2", {27'h0, p2_pu}, 32'h1c);
    chk("drv", {31'h0, drv}, 32'h0);
  endtask : t_option

  task automatic t_unmapped();
    apb(1'b1, 6'h3e, 32'hffff_ffff);
    chk("werr", {31'h0, err}, 32'h1);
    rchk("rdum", 6'h3e, 32'h0);
    chk("rerr", {31'h0, err}, 32'h1);
  endtask : t_unmapped

  task automatic t_rereset();
    do_reset();
    #1;
    chk("oe2", {27'h0, p2_oe_n}, 32'h1f);
    chk("drv", {31'h0, drv}, 32'h1);
    apb(1'b1, bgp_pkg::IDX_ONE_DIR, 32'hff);
    apb(1'b1, bgp_pkg::IDX_TWO_DIR, 32'h1f);
    rchk("keep1", bgp_pkg::IDX_ONE_DATA, 32'h5a);
    rchk("keep2", bgp_pkg::IDX_TWO_DATA, 32'h15);
  endtask : t_rereset

  // ==========================================================
  // verdict
  task automatic end_of_test();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : end_of_test

  initial begin
    error_cnt = 0;
    num_checks = 0;
    presetn = 1'b0;
    {psel, penable, pwrite} = 3'b000;
    paddr = 8'h00;
    pwdata = 32'h0;
    p1_in = 8'h00;
    p2_in = 5'h00;
    p3_in = 8'h00;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    #1;
    t_reset_vals();
    t_port_one();
    t_port_two();
    t_port_three();
    t_option();
    t_unmapped();
    t_rereset();
    end_of_test();
  end
endmodule : tb_bidir_gpio_ports_bcd
`default_nettype wire
